// *** dv/dsdp_bank_monitor.sv ***
`timescale 1ns/1ps
`include "dsdp_consts.vh"
module dsdp_mon (
  input wire clock,
  input wire rst,
  input wire st_rtso, st_swon, st_open, st_volt, st_qstop, st_sod, st_err0, st_halt,
  input wire st_remote, st_tgt, st_limit, st_mode, st_merr, st_mdone, st_refok,
  input wire rd_en,
  input wire wr_en,
  input wire [15:0] addr,
  input wire [15:0] rd_data,
  input wire rd_valid,
  input wire rd_err,
  input wire [3:0] configured_bitrate_param,
  input wire [3:0] active_bitrate_code,
  input wire bitrate_invalid,
  input wire [7:0] node_addr_out
);
  wire rq = rd_en && !wr_en;
  wire [15:0] sw = {st_refok, st_mdone, st_merr, st_mode, st_limit, st_tgt, st_remote,
    st_halt, st_err0, st_sod, st_qstop, st_volt, st_open, st_open, st_swon, st_rtso};
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_wr; wr_en |=> rd_err && !rd_valid; endproperty
  a_wr: assert property (p_wr) else $error("write not refused");
  property p_rd; rq |=> rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_idle; !rd_en && !wr_en |=> !rd_valid && !rd_err; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_st;
    rq && addr == `DSDP_ADDR_STATE && $stable(sw) && !$past(rst) |=> rd_data == $past(sw);
  endproperty
  a_st: assert property (p_st) else $error("state word wrong");
  property p_img; rq && addr == `DSDP_ADDR_DIP_IMAGE |=> rd_data[14:12] == 3'h0; endproperty
  a_img: assert property (p_img) else $error("reserved bits set");
  property p_inv;
    rq && addr == `DSDP_ADDR_BAUD |=>
      bitrate_invalid == !(rd_data[3:0] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h9});
  endproperty
  a_inv: assert property (p_inv) else $error("invalid flag wrong");
  property p_prm;
    rq && addr == `DSDP_ADDR_BAUD ##1 rd_data[3:0] == 4'h9 && $stable(configured_bitrate_param)
      |-> active_bitrate_code == configured_bitrate_param;
  endproperty
  a_prm: assert property (p_prm) else $error("param rate not used");
  property p_node; rq && addr == `DSDP_ADDR_NODE |=> rd_data == {8'h00, node_addr_out}; endproperty
  a_node: assert property (p_node) else $error("node address wrong");
endmodule // dsdp_mon
bind dsdp_bank dsdp_mon mon (.*);

// *** dv/dsdp_master.sv ***
`timescale 1ns/1ps
module dsdp_master (
  // Bus side
  input wire clock,
  input wire [15:0] rd_data,
  input wire rd_valid,
  input wire rd_err,
  output reg rd_en,
  output reg wr_en,
  output reg [15:0] addr,
  output reg [15:0] wr_data
);
  initial {rd_en, wr_en, addr, wr_data} = 34'h0;
  task xfer(input w, input [15:0] a, input [15:0] v, output [15:0] d, output [1:0] e);
    begin
      @(posedge clock);
      rd_en <= !w;
      wr_en <= w;
      addr <= a;
      wr_data <= v;
      @(posedge clock);
      {rd_en, wr_en} <= 2'h0;
      // Released lines show the inverse, not the old value
      addr <= ~a;
      wr_data <= ~v;
      #1;
      d = rd_data;
      e = {rd_valid, rd_err};
    end
  endtask
endmodule // dsdp_master

// *** dv/tb.sv ***
`timescale 1ns/1ps
`include "dsdp_consts.vh"
module tb;
  reg clock = 0;
  reg rst = 1;
  reg [14:0] s = 0;
  reg [11:0] dip = 0;
  reg [3:0] cfg = 4'h5;
  reg [15:0] d;
  reg [1:0] e;
  wire rd_en, wr_en, rd_valid, rd_err, bitrate_invalid;
  wire [15:0] addr, wr_data, rd_data;
  wire [3:0] active_bitrate_code;
  wire [7:0] node_addr_out;
  integer fail_count = 0;
  integer n_compared = 0;
  integer i;
  initial forever #2 clock = ~clock;
  dsdp_bank dut (.clock(clock), .rst(rst), .st_rtso(s[0]), .st_swon(s[1]), .st_open(s[2]),
    .st_volt(s[3]), .st_qstop(s[4]), .st_sod(s[5]), .st_err0(s[6]), .st_halt(s[7]),
    .st_remote(s[8]), .st_tgt(s[9]), .st_limit(s[10]), .st_mode(s[11]), .st_merr(s[12]),
    .st_mdone(s[13]), .st_refok(s[14]), .temp_in(16'h8123), .dip_pins(dip),
    .configured_bitrate_param(cfg), .rd_en(rd_en), .wr_en(wr_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err),
    .active_bitrate_code(active_bitrate_code), .bitrate_invalid(bitrate_invalid),
    .node_addr_out(node_addr_out));
  dsdp_master m (.clock(clock), .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err),
    .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wr_data(wr_data));
  task chk(input [39:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rd(input [15:0] a);
    m.xfer(1'h0, a, 16'h0000, d, e);
  endtask
  // Switches only count at power-on, so each setting needs a reset
  task power(input [11:0] v);
    begin
      @(posedge clock);
      dip <= v;
      rst <= 1;
      repeat (2) @(posedge clock);
      rst <= 0;
      repeat (5) @(posedge clock);
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #20000;
    fail_count = fail_count + 1;
    complete_run;
  end
  initial begin
    power(12'h2a9);
    for (i = 0; i < 15; i = i + 1) begin
      @(posedge clock);
      s <= 15'h0001 << i;
      repeat (2) @(posedge clock);
      rd(`DSDP_ADDR_STATE);
      chk("state", d, {s[14:3], s[2], s[2:0]});
    end
    rd(`DSDP_ADDR_TEMP);
    chk("temp", d, 16'h8123);
    rd(`DSDP_ADDR_BAUD);
    chk("baud", d, 16'h0009);
    chk("act", {12'h000, active_bitrate_code}, {12'h000, cfg});
    rd(`DSDP_ADDR_DIP_IMAGE);
    chk("image", d, 16'h02a9);
    @(posedge clock);
    dip <= 12'h3c6;
    repeat (4) @(posedge clock);
    m.xfer(1'h1, `DSDP_ADDR_DIP_IMAGE, 16'hffff, d, e);
    chk("werr", {14'h0000, e}, 16'h0001);
    rd(`DSDP_ADDR_DIP_IMAGE);
    chk("image", d, 16'h83c6);
    rd(`DSDP_ADDR_NODE);
    chk("node", d, 16'h002a);
    rd(16'h0000);
    chk("uerr", {e, d[13:0]}, 16'hc000);
    for (i = 0; i < 16; i = i + 1) begin
      power({8'h11, i[3:0]});
      chk("inval", {15'h0000, bitrate_invalid}, !(i inside {2, 3, 4, 5, 7, 9}));
      if (i inside {2, 3, 4, 5, 7})
        chk("code", {12'h000, active_bitrate_code}, i);
    end
    rd(`DSDP_ADDR_DIP_IMAGE);
    chk("image", d, 16'h011f);
    complete_run;
  end
endmodule // tb

// *** logic/dsdp_bank.v ***
// How it works
// - State bits 0,1,2: ready-to-switch-on, switched-on, operation-enabled
// - Bit 4 voltage enabled, bit 5 quick stop, bit 6 switch-on disabled
// - Bit 7 class 0 error present, bit 8 halt request active
// - Bit 9 remote, bit 10 target reached, bit 11 internal limit
// - Bit 12 mode-specific, 13 motion error, 14 motion done, 15 homing valid
// - Node address shown; switch changes take effect only after next power-on
// - Bit rate codes 2,3,4,5,7 mean 50k,125k,250k,500k,1M
// - Code 9 takes bit rate from configured parameter instead
// - Codes 0,1,6,8 and above 9 are unsupported and flagged invalid
// - Switch image bits 0-11 switch positions, bits 12-14 reserved zero
// - Switch image bit 15 set when switches changed since power-on
`timescale 1ns/1ps
`include "dsdp_consts.vh"
module dsdp_bank #(
  parameter SW_W = 12,
  parameter ADDR_W = 16,
  parameter BAUD_W = 4
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Drive state sources
  input wire st_rtso,
  input wire st_swon,
  input wire st_open,
  input wire st_volt,
  input wire st_qstop,
  input wire st_sod,
  input wire st_err0,
  input wire st_halt,
  input wire st_remote,
  input wire st_tgt,
  input wire st_limit,
  input wire st_mode,
  input wire st_merr,
  input wire st_mdone,
  input wire st_refok,
  input wire [15:0] temp_in,
  // DIP switch pins
  input wire [SW_W-1:0] dip_pins,
  input wire [BAUD_W-1:0] configured_bitrate_param,
  // Parameter access
  input wire rd_en,
  input wire wr_en,
  input wire [ADDR_W-1:0] addr,
  input wire [15:0] wr_data,
  output reg [15:0] rd_data,
  output reg rd_valid,
  output reg rd_err,
  // Decoded link settings
  output reg [BAUD_W-1:0] active_bitrate_code,
  output reg bitrate_invalid,
  output reg [7:0] node_addr_out
);
  // ****************************************
  // Switch synchroniser and power-on capture
  // ****************************************
  reg [SW_W-1:0] dip_s1_r;
  reg [SW_W-1:0] dip_s2_r;
  reg [SW_W-1:0] dip_boot_r;
  reg boot_done_r;
  reg [1:0] boot_cnt_r;
  reg sw_chg_r;
  reg [15:0] state_r;
  reg [15:0] temp_r;
  reg [15:0] rd_nxt;
  reg hit_nxt;
  reg [BAUD_W-1:0] baud_nxt;
  reg bad_nxt;
  wire [BAUD_W-1:0] sw_baud;
  wire [7:0] sw_node;
  // Switch layout: low nibble bit rate, upper byte node address
  assign sw_baud = dip_boot_r[BAUD_W-1:0];
  assign sw_node = dip_boot_r[SW_W-1:BAUD_W];

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      dip_s1_r <= {SW_W{1'b0}};
      dip_s2_r <= {SW_W{1'b0}};
      dip_boot_r <= {SW_W{1'b0}};
      boot_done_r <= 1'b0;
      boot_cnt_r <= 2'h0;
      sw_chg_r <= 1'b0;
    end else begin
      dip_s1_r <= dip_pins;
      dip_s2_r <= dip_s1_r;
      // Latched once after reset; later moves wait for next power-on
      // Capture waits for the synchroniser, else reset zeros get latched
      if (!boot_done_r) begin
        if (boot_cnt_r == `DSDP_BOOT_WAIT) begin
          dip_boot_r <= dip_s2_r;
          boot_done_r <= 1'b1;
        end else begin
          boot_cnt_r <= boot_cnt_r + 2'h1;
        end
      end else if (dip_s2_r != dip_boot_r) begin
        sw_chg_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // Bit rate decode
  // ****************************************
  always @* begin
    baud_nxt = sw_baud;
    bad_nxt = 1'b0;
    case (sw_baud)
      `DSDP_BAUD_50K, `DSDP_BAUD_125K, `DSDP_BAUD_250K,
      `DSDP_BAUD_500K, `DSDP_BAUD_1M: begin
        baud_nxt = sw_baud;
      end
      `DSDP_BAUD_PARAM: begin
        baud_nxt = configured_bitrate_param;
      end
      default: begin
        bad_nxt = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Register sampling
  // ****************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= `DSDP_ZERO16;
      temp_r <= `DSDP_ZERO16;
      active_bitrate_code <= {BAUD_W{1'b0}};
      bitrate_invalid <= 1'b0;
      node_addr_out <= 8'h00;
    end else begin
      state_r[`DSDP_ST_RTSO] <= st_rtso;
      state_r[`DSDP_ST_SWON] <= st_swon;
      state_r[`DSDP_ST_OPEN] <= st_open;
      state_r[`DSDP_ST_OPEN2] <= st_open;
      state_r[`DSDP_ST_VOLT] <= st_volt;
      state_r[`DSDP_ST_QSTOP] <= st_qstop;
      state_r[`DSDP_ST_SOD] <= st_sod;
      state_r[`DSDP_ST_ERR0] <= st_err0;
      state_r[`DSDP_ST_HALT] <= st_halt;
      state_r[`DSDP_ST_REMOTE] <= st_remote;
      state_r[`DSDP_ST_TGT] <= st_tgt;
      state_r[`DSDP_ST_LIMIT] <= st_limit;
      state_r[`DSDP_ST_MODE] <= st_mode;
      state_r[`DSDP_ST_MERR] <= st_merr;
      state_r[`DSDP_ST_MDONE] <= st_mdone;
      state_r[`DSDP_ST_REFOK] <= st_refok;
      temp_r <= temp_in;
      active_bitrate_code <= baud_nxt;
      bitrate_invalid <= bad_nxt & boot_done_r;
      node_addr_out <= sw_node;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always @* begin
    rd_nxt = `DSDP_ZERO16;
    hit_nxt = 1'b1;
    case (addr)
      `DSDP_ADDR_STATE: rd_nxt = state_r;
      `DSDP_ADDR_TEMP: rd_nxt = temp_r;
      `DSDP_ADDR_BAUD: rd_nxt = {{(16-BAUD_W){1'b0}}, sw_baud};
      `DSDP_ADDR_NODE: rd_nxt = {8'h00, sw_node};
      `DSDP_ADDR_DIP_IMAGE: begin
        rd_nxt[SW_W-1:0] = dip_s2_r;
        rd_nxt[`DSDP_SW_CHG_BIT] = sw_chg_r;
      end
      default: hit_nxt = 1'b0;
    endcase
  end

  // Writes never reach storage; wr_data deliberately unused
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data <= `DSDP_ZERO16;
      rd_valid <= 1'b0;
      rd_err <= 1'b0;
    end else begin
      rd_valid <= rd_en & ~wr_en;
      rd_data <= (rd_en & ~wr_en & hit_nxt) ? rd_nxt : `DSDP_ZERO16;
      rd_err <= (rd_en & ~wr_en & ~hit_nxt) | wr_en;
    end
  end
endmodule // dsdp_bank

// *** logic/dsdp_consts.vh ***
`ifndef DSDP_CONSTS_VH
`define DSDP_CONSTS_VH
// ****************************************
// Register offsets (Modbus addresses, hex)
// ****************************************
`define DSDP_ADDR_DIP_IMAGE 16'h025A
`define DSDP_ADDR_STATE 16'h1B04
`define DSDP_ADDR_TEMP 16'h1C24
`define DSDP_ADDR_BAUD 16'h4120
// No printed address; chosen
`define DSDP_ADDR_NODE 16'hF000
// ****************************************
// Drive state word fields
// ****************************************
`define DSDP_ST_RTSO 0
`define DSDP_ST_SWON 1
`define DSDP_ST_OPEN 2
`define DSDP_ST_OPEN2 3
`define DSDP_ST_VOLT 4
`define DSDP_ST_QSTOP 5
`define DSDP_ST_SOD 6
`define DSDP_ST_ERR0 7
`define DSDP_ST_HALT 8
`define DSDP_ST_REMOTE 9
`define DSDP_ST_TGT 10
`define DSDP_ST_LIMIT 11
`define DSDP_ST_MODE 12
`define DSDP_ST_MERR 13
`define DSDP_ST_MDONE 14
`define DSDP_ST_REFOK 15
// ****************************************
// Switch image and bit rate codes
// ****************************************
`define DSDP_SW_BITS 12
`define DSDP_SW_CHG_BIT 15
`define DSDP_BAUD_50K 4'h2
`define DSDP_BAUD_125K 4'h3
`define DSDP_BAUD_250K 4'h4
`define DSDP_BAUD_500K 4'h5
`define DSDP_BAUD_1M 4'h7
`define DSDP_BAUD_PARAM 4'h9
`define DSDP_ZERO16 16'h0000
// Edges spent filling the switch synchroniser before capture
`define DSDP_BOOT_WAIT 2'h2
`endif
